/* File: hdl/kp_keypad_node.sv */
// Keypad node message logic: frame decode, responses, backlight command, sleep flag, registers.
`timescale 1ns/1ps
`include "kp_consts.svh"

// Behaviour
// (RULE_01) Master starts every exchange on the bus.
// (RULE_02) Answer recognised headers; keep sampling and lighting.
// (RULE_03) Identifier 0xCA returns one node status byte.
// (RULE_04) Status byte: bus error MSB, change LSB.
// (RULE_05) Application field designer-defined; zero means nothing.
// (RULE_06) Button press updates the application status field.
// (RULE_07) Count bit and checksum errors, not reported.
// (RULE_08) Identifier 0x8B returns two button bytes.
// (RULE_09) Thirteen button bits plus one change bit.
// (RULE_10) Change bit is byte 0 bit 7.
// (RULE_11) Identifier 0x4C accepts one backlight byte.
// (RULE_12) Four-bit brightness, 6.65 percent per step; the code lights one more slot of 15 per step, about 6.67 percent.
// (RULE_13) MSB off disables light, ignores level.
// (RULE_14) Drive backlight from latest received level.
// (RULE_15) Identifier 0x80 alone is the sleep request.
// (RULE_16) Sleep request sets a flag software polls.
// (RULE_17) Identifier 0x3C sleep form not supported.
// (RULE_18) Master polls status, reads buttons on LSB.
// (RULE_19) Master alternates buttons and backlight schedules.
// (RULE_20) Ignore other identifiers, never drive response.
module kp_keypad_node (
  input wire logic i_clk,
  input wire logic i_rst,
  // Avalon-MM slave.
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Frame events from the serial driver, same clock.
  input wire logic i_hdr_valid,
  input wire logic [7:0] i_hdr_pid,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  input wire logic i_rx_err_bit,
  input wire logic i_rx_err_cksum,
  // Response bytes toward the serial driver.
  output logic o_tx_valid,
  output logic [7:0] o_tx_data,
  input wire logic i_tx_ready,
  // Button pins, asynchronous.
  input wire logic [12:0] i_buttons,
  // Outputs to the application and the lamp driver.
  output logic o_sleep_request,
  output logic o_backlight_pwm
);
  import kp_pkg::*;

  // Saturating increment for the error counters.
  function automatic logic [7:0] sat_inc(input logic [7:0] v, input logic hit);
    sat_inc = (hit && v != 8'hFF) ? v + 8'h01 : v;
  endfunction

  // Code of the lowest newly pressed button, plus one; zero when none.
  function automatic logic [3:0] press_code(input logic [12:0] p);
    press_code = 4'h0;
    for (int i = `KP_NUM_BUTTONS - 1; i >= 0; i--) begin
      if (p[i]) begin
        press_code = 4'(i + 1);
      end
    end
  endfunction

  // Button synchroniser and edge detector.
  logic [12:0] btn_meta; // First stage, read only by the second.
  logic [12:0] btn; // Synchronised button levels.
  logic [12:0] btn_prev; // Levels one cycle earlier.
  logic [12:0] press; // One-cycle pulse per new press.

  // Register bus state.
  logic wait_q; // Waitrequest, high in the first cycle of a request.
  logic next_wait;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic ctrl_en; // Response enable, software writable.
  logic next_ctrl_en;
  logic wr_ctrl; // Accepted write to the control register.

  // Frame and flag state.
  kp_state_t state;
  kp_state_t next_state;
  logic next_tx_valid;
  logic [7:0] next_tx_data;
  logic tx_more; // Second response byte still pending.
  logic next_tx_more;
  logic [7:0] tx_b1; // Second response byte.
  logic [7:0] next_tx_b1;
  logic chg; // Any-button change flag.
  logic next_chg;
  logic [3:0] app_code; // Application status code of the last press.
  logic [3:0] next_app_code;
  logic next_sleep;
  logic [7:0] light; // Latest backlight command byte.
  logic [7:0] next_light;
  logic [7:0] err_bit_cnt;
  logic [7:0] next_err_bit_cnt;
  logic [7:0] err_ck_cnt;
  logic [7:0] next_err_ck_cnt;
  logic [7:0] stat_byte; // Node status byte as it would be sent now.
  logic [7:0] key_b0; // First button report byte.
  logic report; // A response carrying the change flag starts.

  // Buttons cross from the pins through two flops before any use.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      btn_meta <= 13'h0000;
      btn <= 13'h0000;
      btn_prev <= 13'h0000;
    end else begin
      btn_meta <= i_buttons;
      btn <= btn_meta;
      btn_prev <= btn; // RULE_02
    end
  end

  // Rising edges of the synchronised buttons.
  assign press = btn & ~btn_prev;

  // Register bus: one wait cycle, then the answer.
  always_comb begin
    next_wait = 1'h1;
    next_rdata = rdata;
    next_ctrl_en = ctrl_en;
    wr_ctrl = 1'h0;
    if ((i_avs_read || i_avs_write) && wait_q) begin
      // First cycle: release waitrequest and prepare read data.
      next_wait = 1'h0;
      next_rdata = 32'h00000000;
      if (i_avs_read) begin
        unique case (i_avs_address)
          `KP_REG_STATUS: next_rdata = {3'h0, btn, 7'h00, o_sleep_request, stat_byte};
          `KP_REG_CTRL: next_rdata = {29'h00000000, ctrl_en, 2'h0};
          `KP_REG_ERRCNT: next_rdata = {16'h0000, err_ck_cnt, err_bit_cnt};
          `KP_REG_LIGHT: next_rdata = {24'h000000, light};
          default: next_rdata = 32'h00000000; // Unmapped reads return zero.
        endcase
      end
    end else if (i_avs_write && !wait_q) begin
      // Write takes effect on the edge where waitrequest is low.
      if (i_avs_address == `KP_REG_CTRL && i_avs_byteenable[0]) begin
        wr_ctrl = 1'h1;
        next_ctrl_en = i_avs_writedata[`KP_CTRL_EN];
      end
    end
  end

  // Register bus flops.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wait_q <= 1'h1;
      rdata <= 32'h00000000;
      ctrl_en <= `KP_CTRL_EN_RST;
    end else begin
      wait_q <= next_wait;
      rdata <= next_rdata;
      ctrl_en <= next_ctrl_en;
    end
  end

  assign o_avs_waitrequest = wait_q;
  assign o_avs_readdata = rdata;

  // Status byte: bus error in the MSB (not reported, so zero), code and change flag low.
  assign stat_byte = {1'h0, 2'h0, app_code, chg}; // RULE_04 RULE_05 RULE_07

  // Button report byte 0: change flag in bit 7, cruise buttons low.
  assign key_b0 = {chg, 2'h0, btn[`KP_NUM_CRUISE-1:0]}; // RULE_09 RULE_10

  // Frame handling, flags and counters.
  always_comb begin
    next_state = state;
    next_tx_valid = o_tx_valid;
    next_tx_data = o_tx_data;
    next_tx_more = tx_more;
    next_tx_b1 = tx_b1;
    next_light = light;
    report = 1'h0;
    next_sleep = o_sleep_request;
    // Errors are counted whatever the frame.
    next_err_bit_cnt = sat_inc(err_bit_cnt, i_rx_err_bit); // RULE_07
    next_err_ck_cnt = sat_inc(err_ck_cnt, i_rx_err_cksum); // RULE_07
    if (wr_ctrl && i_avs_writedata[`KP_CTRL_CLR_SLEEP]) begin
      next_sleep = 1'h0;
    end
    unique case (state)
      KP_SEND: begin
        // Hand response bytes to the driver one at a time.
        if (o_tx_valid && i_tx_ready) begin
          if (tx_more) begin
            next_tx_data = tx_b1;
            next_tx_more = 1'h0;
          end else begin
            next_tx_valid = 1'h0;
            next_state = KP_IDLE;
          end
        end
      end
      KP_CMD: begin
        // The single data byte of the backlight command.
        if (i_rx_valid) begin
          next_light = i_rx_data; // RULE_11 RULE_14
          next_state = KP_IDLE;
        end
      end
      default: begin
        next_state = KP_IDLE;
      end
    endcase
    // A new header always ends any exchange in progress.
    if (i_hdr_valid) begin
      next_state = KP_IDLE;
      next_tx_valid = 1'h0;
      next_tx_more = 1'h0;
      if (ctrl_en) begin // RULE_02
        unique case (i_hdr_pid)
          `KP_PID_STATUS: begin
            next_state = KP_SEND;
            next_tx_valid = 1'h1;
            next_tx_data = stat_byte; // RULE_03
            report = 1'h1;
          end
          `KP_PID_BUTTONS: begin
            next_state = KP_SEND;
            next_tx_valid = 1'h1;
            next_tx_data = key_b0; // RULE_08
            next_tx_b1 = btn[`KP_NUM_BUTTONS-1:`KP_NUM_CRUISE]; // RULE_08
            next_tx_more = 1'h1;
            report = 1'h1;
          end
          `KP_PID_LIGHT: begin
            next_state = KP_CMD; // RULE_11
          end
          `KP_PID_SLEEP: begin
            next_sleep = 1'h1; // RULE_15 RULE_16
          end
          `KP_PID_DIAG: begin
            next_state = KP_IDLE; // RULE_17
          end
          default: begin
            next_state = KP_IDLE; // RULE_20
          end
        endcase
      end
    end
    // Change flag and code clear once reported; a new press wins over the clear.
    next_chg = chg;
    next_app_code = app_code;
    if (report || (wr_ctrl && i_avs_writedata[`KP_CTRL_CLR_CHG])) begin
      next_chg = 1'h0;
      next_app_code = 4'h0;
    end
    if (|press) begin
      next_chg = 1'h1; // RULE_06
      next_app_code = press_code(press); // RULE_06
    end
  end

  // Frame handling flops.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state <= KP_IDLE;
      o_tx_valid <= 1'h0;
      o_tx_data <= 8'h00;
      tx_more <= 1'h0;
      tx_b1 <= 8'h00;
      chg <= 1'h0;
      app_code <= 4'h0;
      o_sleep_request <= 1'h0;
      light <= `KP_LIGHT_RST;
      err_bit_cnt <= 8'h00;
      err_ck_cnt <= 8'h00;
    end else begin
      state <= next_state;
      o_tx_valid <= next_tx_valid;
      o_tx_data <= next_tx_data;
      tx_more <= next_tx_more;
      tx_b1 <= next_tx_b1;
      chg <= next_chg;
      app_code <= next_app_code;
      o_sleep_request <= next_sleep;
      light <= next_light;
      err_bit_cnt <= next_err_bit_cnt;
      err_ck_cnt <= next_err_ck_cnt;
    end
  end

  // Backlight modulator runs continuously from the latest command.
  kp_backlight_pwm u_pwm (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_on(light[`KP_LIGHT_ON_BIT]),
    .i_level(light[3:0]),
    .o_pwm(o_backlight_pwm)
  );

endmodule

/* File: hdl/kp_consts.svh */
// Constants for the keypad node message logic: identifiers, offsets, fields and timing.
`ifndef KP_CONSTS_SVH
`define KP_CONSTS_SVH

// Protected identifiers that the keypad recognises.
`define KP_PID_STATUS 8'hCA
`define KP_PID_BUTTONS 8'h8B
`define KP_PID_LIGHT 8'h4C
`define KP_PID_SLEEP 8'h80
`define KP_PID_DIAG 8'h3C

// Register byte offsets on the Avalon-MM slave.
`define KP_REG_STATUS 4'h0
`define KP_REG_CTRL 4'h4
`define KP_REG_ERRCNT 4'h8
`define KP_REG_LIGHT 4'hC

// Field positions.
`define KP_STAT_ERR_BIT 7
`define KP_STAT_CHG_BIT 0
`define KP_KEY_CHG_BIT 7
`define KP_LIGHT_ON_BIT 7
`define KP_CTRL_CLR_SLEEP 0
`define KP_CTRL_CLR_CHG 1
`define KP_CTRL_EN 2
`define KP_NUM_BUTTONS 13
`define KP_NUM_CRUISE 5

// Reset values.
`define KP_CTRL_EN_RST 1'h1
`define KP_LIGHT_RST 8'h00

// Timing: clock period, brightness slot time and the derived cycle count.
`define KP_CLK_PERIOD_PS 4000
`define KP_PWM_SLOT_NS 10000
`define KP_PWM_SLOT_CYCLES ((`KP_PWM_SLOT_NS * 1000) / `KP_CLK_PERIOD_PS)
`define KP_PWM_STEPS 15

`endif

/* File: hdl/kp_pkg.sv */
// Types shared by the keypad node message logic.
package kp_pkg;

  // Frame handling states, one-hot.
  typedef enum logic [2:0] {
    KP_IDLE = 3'h1,
    KP_SEND = 3'h2,
    KP_CMD = 3'h4
  } kp_state_t;

endpackage

/* File: hdl/kp_backlight_pwm.sv */
// Backlight brightness modulator: 15 slots per period, one slot per brightness step.
`timescale 1ns/1ps
`include "kp_consts.svh"

module kp_backlight_pwm (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_on,
  input wire logic [3:0] i_level,
  output logic o_pwm
);
  import kp_pkg::*;

  localparam logic [11:0] SLOT_LAST = 12'(`KP_PWM_SLOT_CYCLES - 1); // Divider end value.
  localparam logic [3:0] STEP_LAST = 4'(`KP_PWM_STEPS - 1); // Last slot of a period.

  logic [11:0] div; // Slot divider.
  logic [11:0] next_div;
  logic [3:0] slot; // Slot within the period.
  logic [3:0] next_slot;
  logic [3:0] duty; // Level latched at period start so a period never glitches.
  logic [3:0] next_duty;
  logic next_pwm;
  logic tick; // One-cycle enable at the end of each slot.

  // Divider, slot counter and output level.
  always_comb begin
    tick = (div == SLOT_LAST);
    next_div = tick ? 12'h000 : div + 12'h001;
    next_slot = slot;
    next_duty = duty;
    if (tick) begin
      if (slot == STEP_LAST) begin
        next_slot = 4'h0;
        // An off command forces zero duty whatever the level says.
        next_duty = i_on ? i_level : 4'h0; // RULE_13
      end else begin
        next_slot = slot + 4'h1;
      end
    end
    // Each level step lights one more slot of fifteen.
    next_pwm = (slot < duty); // RULE_12
  end

  // Registers of the modulator.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      div <= 12'h000;
      slot <= 4'h0;
      duty <= 4'h0;
      o_pwm <= 1'h0;
    end else begin
      div <= next_div;
      slot <= next_slot;
      duty <= next_duty;
      o_pwm <= next_pwm; // RULE_14
    end
  end

endmodule

/* File: test/kp_keypad_node_monitor.sv */
// Checker for the keypad node ports: frame answers, sleep flag and bus wait timing.
`timescale 1ns/1ps
module kp_keypad_node_monitor (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic o_avs_waitrequest,
  input wire logic i_hdr_valid,
  input wire logic [7:0] i_hdr_pid,
  input wire logic o_tx_valid,
  input wire logic [7:0] o_tx_data,
  input wire logic i_tx_ready,
  input wire logic o_sleep_request
);
  // Every check samples on the rising edge and rests while reset is high.
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  property p_stat; i_hdr_valid && i_hdr_pid == 8'hCA |=> o_tx_valid && !o_tx_data[7]; endproperty
  a_stat: assert property (p_stat) else $error("status header gave no proper byte");
  property p_btn; i_hdr_valid && i_hdr_pid == 8'h8B |=> o_tx_valid && o_tx_data[6:5] == 2'h0; endproperty
  a_btn: assert property (p_btn) else $error("button header gave no proper byte");
  property p_quiet; i_hdr_valid && !(i_hdr_pid inside {8'hCA, 8'h8B}) |=> !o_tx_valid; endproperty
  a_quiet: assert property (p_quiet) else $error("response driven for a silent header");
  property p_unsol; !o_tx_valid && !i_hdr_valid |=> !o_tx_valid; endproperty
  a_unsol: assert property (p_unsol) else $error("response offered without a header");
  property p_hold; o_tx_valid && !i_tx_ready && !i_hdr_valid |=> o_tx_valid && $stable(o_tx_data); endproperty
  a_hold: assert property (p_hold) else $error("response byte changed before it was taken");
  property p_sleep; i_hdr_valid && i_hdr_pid == 8'h80 |=> o_sleep_request; endproperty
  a_sleep: assert property (p_sleep) else $error("sleep header did not set the flag");
  property p_keep; o_sleep_request && !i_avs_write |=> o_sleep_request; endproperty
  a_keep: assert property (p_keep) else $error("sleep flag dropped without software");
  property p_nosleep; !o_sleep_request && !(i_hdr_valid && i_hdr_pid == 8'h80) |=> !o_sleep_request; endproperty
  a_nosleep: assert property (p_nosleep) else $error("sleep flag set without its header");
  property p_wait; (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest ##1 o_avs_waitrequest;
  endproperty
  a_wait: assert property (p_wait) else $error("bus answer not in the second cycle");
endmodule
bind kp_keypad_node kp_keypad_node_monitor u_mon (.i_clk, .i_rst, .i_avs_read, .i_avs_write, .o_avs_waitrequest,
  .i_hdr_valid, .i_hdr_pid, .o_tx_valid, .o_tx_data, .i_tx_ready, .o_sleep_request);

/* File: test/kp_lin_master.sv */
// Bus master model: sends headers and command bytes, takes response bytes.
`timescale 1ns/1ps
module kp_lin_master (
  input wire logic i_clk,
  input wire logic i_tx_valid,
  input wire logic [7:0] i_tx_data,
  output logic o_hdr_valid = 1'b0,
  output logic [7:0] o_hdr_pid = 8'h00,
  output logic o_rx_valid = 1'b0,
  output logic [7:0] o_rx_data = 8'h00,
  output logic o_tx_ready = 1'b0
);
  // Sends one header pulse; released lines show the inverse so no stale value lingers.
  task automatic header(input logic [7:0] pid);
    o_hdr_valid <= 1'b1;
    o_hdr_pid <= pid;
    @(posedge i_clk);
    o_hdr_valid <= 1'b0;
    o_hdr_pid <= ~pid;
  endtask
  // Sends one command data byte.
  task automatic send_byte(input logic [7:0] d);
    o_rx_valid <= 1'b1;
    o_rx_data <= d;
    @(posedge i_clk);
    o_rx_valid <= 1'b0;
    o_rx_data <= ~d;
  endtask
  // Takes one response byte after a stall of gap cycles; ok is low on a hang.
  task automatic take(input int gap, output logic [7:0] d, output logic ok);
    int n;
    n = 0;
    @(negedge i_clk);
    while (i_tx_valid !== 1'b1 && n < 50) begin
      @(negedge i_clk);
      n++;
    end
    repeat (gap) @(negedge i_clk);
    d = i_tx_data;
    ok = (n < 50);
    @(posedge i_clk);
    o_tx_ready <= 1'b1;
    @(posedge i_clk);
    o_tx_ready <= 1'b0;
  endtask
endmodule

/* File: test/lin_keypad_slave_messages_tb.sv */
// Self-checking bench for the keypad node message logic.
`timescale 1ns/1ps
`include "kp_consts.svh"
module lin_keypad_slave_messages_tb;
  logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, eb = 1'b0, ec = 1'b0;
  logic rdy, txv, slp, pwm, wt, hv, rv;
  logic [3:0] ad = 4'h0;
  logic [3:0] be = 4'hF;
  logic [31:0] wd = 32'h0, rdat, v;
  logic [7:0] pid, rxd, txd, b;
  logic [12:0] btn = 13'h0;
  logic [3:0] ra [5] = '{4'h0, 4'h4, 4'h8, 4'hC, 4'h2};
  logic [31:0] re [5] = '{32'h0, 32'h4, 32'h0, 32'h0, 32'h0};
  int errors = 0, cmp_count = 0, hi;
  kp_keypad_node uut (.i_clk(clk), .i_rst(rst), .i_avs_address(ad), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_byteenable(be), .i_avs_writedata(wd), .o_avs_readdata(rdat), .o_avs_waitrequest(wt),
    .i_hdr_valid(hv), .i_hdr_pid(pid), .i_rx_valid(rv), .i_rx_data(rxd), .i_rx_err_bit(eb),
    .i_rx_err_cksum(ec), .o_tx_valid(txv), .o_tx_data(txd), .i_tx_ready(rdy), .i_buttons(btn),
    .o_sleep_request(slp), .o_backlight_pwm(pwm));
  kp_lin_master m (.i_clk(clk), .i_tx_valid(txv), .i_tx_data(txd), .o_hdr_valid(hv), .o_hdr_pid(pid),
    .o_rx_valid(rv), .o_rx_data(rxd), .o_tx_ready(rdy));
  // The 250 MHz clock.
  initial begin
    forever #2 clk = ~clk;
  end
  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Compares one value and reports a mismatch.
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", s, e, g);
    end
  endtask
  // One bus access; the request holds until waitrequest is seen low at an edge.
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    ad <= a;
    wd <= d;
    wr <= w;
    rd <= ~w;
    @(posedge clk);
    while (wt !== 1'b0 && n < 20) begin
      @(posedge clk);
      n++;
    end
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge clk);
    if (n >= 20) begin
      errors++;
      finish_test;
    end
  endtask
  // Takes one response byte and compares it.
  task automatic rx(input int g, input logic [7:0] e, input string s);
    logic ok;
    m.take(g, b, ok);
    if (ok !== 1'b1) begin
      errors++;
      finish_test;
    end
    chk(s, {24'h0, e}, {24'h0, b});
  endtask
  // Counts lamp-high cycles over a window.
  task automatic lamp(input int n);
    hi = 0;
    repeat (n) begin
      @(negedge clk);
      if (pwm === 1'b1) hi++;
    end
    @(posedge clk);
  endtask
  // Checks the sleep flag mid-cycle.
  task automatic sl(input logic e);
    @(negedge clk);
    chk("sleep", {31'h0, e}, {31'h0, slp});
    @(posedge clk);
  endtask
  // Main sequence.
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    av(1'b1, 4'h2, 32'hFF, v);
    foreach (ra[i]) begin
      av(1'b0, ra[i], 32'h0, v);
      chk("reset_reg", re[i], v);
    end
    btn <= 13'h0040;
    repeat (5) @(posedge clk);
    m.header(`KP_PID_STATUS);
    rx(0, 8'h0F, "status_byte");
    btn <= 13'h0041;
    repeat (5) @(posedge clk);
    m.header(`KP_PID_BUTTONS);
    rx(3, 8'h81, "keys_byte0");
    rx(0, 8'h02, "keys_byte1");
    m.header(`KP_PID_STATUS);
    rx(2, 8'h00, "status_after");
    av(1'b0, `KP_REG_STATUS, 32'h0, v);
    chk("status_reg", 32'h00410000, v);
    eb <= 1'b1;
    ec <= 1'b1;
    @(posedge clk);
    ec <= 1'b0;
    repeat (2) @(posedge clk);
    eb <= 1'b0;
    @(posedge clk);
    av(1'b0, `KP_REG_ERRCNT, 32'h0, v);
    chk("error_counts", 32'h0103, v);
    m.header(`KP_PID_LIGHT);
    m.send_byte(8'h0F);
    m.send_byte(8'h8F);
    av(1'b0, `KP_REG_LIGHT, 32'h0, v);
    chk("light_off", 32'h0F, v);
    lamp(`KP_PWM_SLOT_CYCLES);
    chk("lamp_off", 32'h0, 32'(hi));
    m.header(`KP_PID_LIGHT);
    m.send_byte(8'h8A);
    repeat (`KP_PWM_STEPS * `KP_PWM_SLOT_CYCLES) @(posedge clk);
    lamp(`KP_PWM_STEPS * `KP_PWM_SLOT_CYCLES);
    chk("lamp_duty", 32'(10 * `KP_PWM_SLOT_CYCLES), 32'(hi));
    m.header(`KP_PID_DIAG);
    m.send_byte(8'h00);
    m.header(8'h55);
    sl(1'b0);
    m.header(`KP_PID_SLEEP);
    sl(1'b1);
    be <= 4'h0;
    av(1'b1, `KP_REG_CTRL, 32'h5, v);
    sl(1'b1);
    be <= 4'hF;
    av(1'b1, `KP_REG_CTRL, 32'h5, v);
    sl(1'b0);
    finish_test;
  end
endmodule
